//--- design/usbev_params.svh
`ifndef USBEV_PARAMS_SVH
`define USBEV_PARAMS_SVH

// ==========================================================================
// Register offsets (byte addresses on the plain register port).
`define USBEV_OFF_BLOCK      8'h00
`define USBEV_OFF_FLAGS      8'h01
`define USBEV_OFF_ENABLES    8'h02
`define USBEV_OFF_CONTROL    8'h03

// ==========================================================================
// Event flag bit positions.
`define USBEV_B_GOOD         7
`define USBEV_B_SETUP_OVERWRITE_FLAG         5
`define USBEV_B_FAULT        4
`define USBEV_B_SLEEP        3
`define USBEV_B_WAKE         2
`define USBEV_B_BUSRST       1
`define USBEV_B_FRAME        0
`define USBEV_FLAG_MASK      8'hBF

// ==========================================================================
// Block control bit positions.
`define USBEV_B_BLKIDX       3
`define USBEV_B_FILL1        2
`define USBEV_B_FILL0        1
`define USBEV_B_WIPE         0

// ==========================================================================
// Interface control bit positions and reset value.
`define USBEV_B_WSEEN        7
`define USBEV_B_RSEEN        6
`define USBEV_B_RESUME       3
`define USBEV_B_PWRDN        2
`define USBEV_B_SLFORCE      1
`define USBEV_B_REINIT       0
`define USBEV_CTRL_RESET     8'h06
`define USBEV_CTRL_WMASK     8'h0F

// ==========================================================================
// Idle time before a sleep request, in microseconds, and clock rate.
`define USBEV_IDLE_US        3000
`define USBEV_CLK_MHZ        40
`define USBEV_IDLE_CYC       (`USBEV_IDLE_US * `USBEV_CLK_MHZ)

`endif

//--- design/usbev_pkg.sv
package usbev_pkg;

  // Endpoint-2 routing select.
  typedef enum logic [1:0] {
    USBEV_ROUTE_NORMAL   = 2'b00,
    USBEV_ROUTE_UPLOAD   = 2'b01,
    USBEV_ROUTE_DOWNLOAD = 2'b10,
    USBEV_ROUTE_RSVD     = 2'b11
  } usbev_route_t;

  // Sleep state of the interface, one-hot.
  typedef enum logic [2:0] {
    USBEV_AWAKE  = 3'b001,
    USBEV_ASLEEP = 3'b010,
    USBEV_RESUME = 3'b100
  } usbev_sleep_t;

endpackage

//--- design/usbev_blk_if.sv
`timescale 1ns/1ps
// ==========================================================================
// Carries endpoint-2 block events into the block tracker and its state back.
interface usbev_blk_if;
  logic       rx_done;   // Endpoint 2 finished a packet.
  logic       rx_block;  // Block that received it.
  logic [1:0] fill_set;  // Per-block fill state set.
  logic [1:0] fill_clr;  // Per-block fill state clear.
  logic       wipe;      // Software wipe request.
  logic       frozen;    // Halt freeze.
  logic       index;     // Active block index.
  logic [1:0] fill;      // Fill state bits.
  logic [3:0] pkt_cnt;   // Packet counter.
  modport tracker (input rx_done, rx_block, fill_set, fill_clr, wipe, frozen,
                   output index, fill, pkt_cnt);
  modport owner (output rx_done, rx_block, fill_set, fill_clr, wipe, frozen,
                 input index, fill, pkt_cnt);
endinterface

//--- design/usbev_blk_track.sv
`timescale 1ns/1ps
`include "usbev_params.svh"
// ==========================================================================
// Tracks the active block index, fill states and packet counter.
module usbev_blk_track
  import usbev_pkg::*;
(
  input  wire logic      clock,  // System clock.
  input  wire logic      rst_b,  // Asynchronous reset, active low.
  input  wire logic      bus_rst, // USB reset, synchronous.
  input  usbev_route_t   route,  // Endpoint-2 routing.
  usbev_blk_if.tracker   blk     // Block events and state.
);

  typedef struct packed {
    logic       index;
    logic [1:0] fill;
    logic [3:0] pkt;
  } usbev_blk_st_t;

  usbev_blk_st_t st_q;
  usbev_blk_st_t st_d;

  // Next state: wipe first, then hardware updates; halt holds everything.
  always_comb begin
    st_d = st_q;
    if (blk.frozen) begin
      st_d = st_q;
    end else if (blk.wipe || bus_rst) begin
      st_d = '0;                                      // [R7]
    end else begin
      if (blk.rx_done) begin
        st_d.pkt = st_q.pkt + 4'h1;
        if (route == USBEV_ROUTE_NORMAL) begin
          st_d.index = blk.rx_block;                  // [R5]
        end
      end
      if (route != USBEV_ROUTE_NORMAL) begin
        st_d.fill = (st_q.fill & ~blk.fill_clr) | blk.fill_set; // [R6]
      end
    end
  end

  // State register.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign blk.index   = st_q.index;
  assign blk.fill    = st_q.fill;
  assign blk.pkt_cnt = st_q.pkt;

endmodule

//--- design/usbev_core.sv
`timescale 1ns/1ps
`include "usbev_params.svh"
// Behaviour
// R1 - In wait the interface runs on; any enabled event wakes the CPU.
// R2 - In halt the interface freezes; it resumes on wake interrupt or bus activity.
// R3 - Wake event has its own halt-exit vector; others share a second vector.
// R4 - Interrupt request when flag set, enable set and global mask clear.
// R5 - Hardware keeps the active block index for endpoint-2 normal receives.
// R6 - Hardware sets and clears block fill states in upload and download routing.
// R7 - Writing 1 to wipe clears index, fill states and packet counter.
// R8 - Event flags set only by hardware; software reads and clears them.
// R9 - Good transfer flag is the OR of endpoint flags, not directly clearable.
// R10 - Good transaction needs clean PID, CRC, toggle, no errors, no NAK/STALL.
// R11 - Good SETUP while endpoint-0 flag set raises overwrite, status not updated.
// R12 - Fault flag set on timeout, CRC, stuffing, framing or overrun error.
// R13 - Idle sleep request after bus idle longer than 3 ms.
// R14 - Idle detection restarts after reset, disabled from forced sleep to resume end.
// R15 - Wake flag set on bus activity during sleep.
// R16 - Bus reset flag set on USB reset; reset also clears address and endpoints.
// R17 - Frame start flag set on every SOF token.
// R18 - Software should clear flags with a plain store, not read-modify-write.
// R19 - Wake sequence seen bit shows a resume has started on the bus.
// R20 - Bus reset seen bit shows a reset sequence has started on the bus.
// R21 - Bus activity clears the force-sleep bit; software may clear it too.
// R22 - Force-reinit holds USB reset; clearing it raises a bus reset event.
// R23 - Writing 0 clears a flag, 1 keeps it; hardware set wins.
// R24 - Reserved bits read zero and ignore writes.
module usbev_core
  import usbev_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = `USBEV_IDLE_CYC  // Idle cycles before sleep request.
) (
  input  wire logic       clock,          // 40 MHz system clock.
  input  wire logic       rst_b,          // Asynchronous reset, active low.
  input  wire logic [7:0] reg_addr,       // Register address.
  input  wire logic [7:0] reg_wdata,      // Register write data.
  input  wire logic       reg_wr,         // Write strobe.
  input  wire logic       reg_rd,         // Read strobe.
  output logic      [7:0] reg_rdata,      // Read data, one cycle after strobe.
  input  wire logic       cpu_halt,       // CPU in halt.
  input  wire logic       cpu_irq_mask,   // CPU global interrupt mask.
  input  wire logic       bus_idle,       // Pin: bus line idle (J state).
  input  wire logic       bus_reset_seq,  // Pin: reset sequence on bus.
  input  wire logic       bus_resume_seq, // Pin: resume sequence on bus.
  input  wire logic       pkt_done,       // Packet finished, same clock.
  input  wire logic       pkt_nak_stall,  // Answered NAK or STALL.
  input  wire logic       pkt_pid_err,    // PID error.
  input  wire logic       pkt_crc_err,    // CRC error.
  input  wire logic       pkt_toggle_bad, // Data toggle mismatch.
  input  wire logic       pkt_stuff_err,  // Bit stuffing error.
  input  wire logic       pkt_frame_err,  // Framing error.
  input  wire logic       pkt_overrun,    // Buffer overrun.
  input  wire logic       pkt_timeout,    // Timeout.
  input  wire logic [1:0] pkt_ep,         // Endpoint number.
  input  wire logic       pkt_setup,      // Token was SETUP.
  input  wire logic       pkt_block,      // Endpoint-2 block used.
  input  wire logic       sof_token,      // SOF token received.
  input  wire logic [2:0] ep_good_clr,    // Endpoint good-transfer clears.
  input  wire logic [1:0] route,          // Endpoint-2 routing select.
  input  wire logic [1:0] fill_set,       // Fill state sets from buffer manager.
  input  wire logic [1:0] fill_clr,       // Fill state clears from buffer manager.
  output logic            irq_wake,       // Halt-exit wake vector request.
  output logic            irq_main,       // Shared event vector request.
  output logic            cpu_wake,       // Wait exit request.
  output logic            usb_reset_out,  // USB reset to address and endpoints.
  output logic            status_write,   // Transaction status may update.
  output logic            resume_drive,   // Resume signal forced on bus.
  output logic            power_down,     // Regulator off.
  output logic      [2:0] ep_good,        // Endpoint good-transfer flags.
  output logic      [3:0] pkt_count       // Buffer manager packet counter.
);

  initial begin
    if (IDLE_CYCLES < 2) $error("IDLE_CYCLES too small");
  end

  localparam int CW = $clog2(IDLE_CYCLES + 1);

  // ========================================================================
  // State.
  typedef struct packed {
    logic [2:0]   sy_idle;      // Two-flop synchronisers, three pins.
    logic [2:0]   sy_rst;
    logic [2:0]   sy_res;
    logic [7:0]   flags;
    logic [7:0]   enables;
    logic [7:0]   ctrl;
    logic [2:0]   epg;
    logic [CW-1:0] idle_cnt;
    usbev_sleep_t sleep;
    logic [7:0]   rdata;
    logic         irq_w;
    logic         irq_m;
    logic         wake;
    logic         urst;
    logic         stw;
  } usbev_st_t;

  usbev_st_t st_q;
  usbev_st_t st_d;

  usbev_blk_if blk ();

  // Good transaction check.
  function automatic logic good_pkt(input logic [7:0] e);
    good_pkt = ~|e;
  endfunction

  logic [7:0] err_vec;
  logic       good;
  logic       fault;
  logic       ovr;
  logic       activity;
  logic       brst;
  logic       frozen;
  logic [7:0] hw_set;
  logic       wr_flags;
  logic       wr_ctrl;
  logic       wr_block;

  // ========================================================================
  // Event decode.
  always_comb begin
    err_vec  = {pkt_nak_stall, pkt_pid_err, pkt_crc_err, pkt_toggle_bad,
                pkt_stuff_err, pkt_frame_err, pkt_overrun, pkt_timeout};
    frozen   = cpu_halt;                                             // [R2]
    good     = pkt_done && good_pkt(err_vec);                        // [R10]
    ovr      = good && pkt_setup && (pkt_ep == 2'b00) && st_q.epg[0]; // [R11]
    fault    = pkt_done && (pkt_timeout | pkt_crc_err | pkt_stuff_err
                            | pkt_frame_err | pkt_overrun);          // [R12]
    activity = !st_q.sy_idle[1] || st_q.sy_res[1] || st_q.sy_rst[1];
    brst     = st_q.sy_rst[1] || st_q.ctrl[`USBEV_B_REINIT];         // [R22]
    wr_flags = reg_wr && (reg_addr == `USBEV_OFF_FLAGS);
    wr_ctrl  = reg_wr && (reg_addr == `USBEV_OFF_CONTROL);
    wr_block = reg_wr && (reg_addr == `USBEV_OFF_BLOCK);
    hw_set   = '0;
  end

  // ========================================================================
  // Next state.
  always_comb begin
    st_d = st_q;
    st_d.sy_idle = {st_q.sy_idle[1:0], bus_idle};
    st_d.sy_rst  = {st_q.sy_rst[1:0], bus_reset_seq};
    st_d.sy_res  = {st_q.sy_res[1:0], bus_resume_seq};
    st_d.rdata   = '0;
    st_d.stw     = 1'b0;
    if (reg_rd) begin
      case (reg_addr)
        `USBEV_OFF_BLOCK:   st_d.rdata = {4'h0, blk.index, blk.fill, 1'b0}; // [R24]
        `USBEV_OFF_FLAGS:   st_d.rdata = st_q.flags & `USBEV_FLAG_MASK;
        `USBEV_OFF_ENABLES: st_d.rdata = st_q.enables & `USBEV_FLAG_MASK;
        `USBEV_OFF_CONTROL: st_d.rdata = st_q.ctrl & 8'hCF;
        default:            st_d.rdata = '0;
      endcase
    end
    if (!frozen) begin
      // Software writes; flag writes only clear, but a reinit release sets the bus reset flag.
      if (wr_flags) begin
        st_d.flags = st_q.flags & reg_wdata & `USBEV_FLAG_MASK;        // [R8] [R23]
      end
      if (reg_wr && reg_addr == `USBEV_OFF_ENABLES) begin
        st_d.enables = reg_wdata & `USBEV_FLAG_MASK;                   // [R24]
      end
      if (wr_ctrl) begin
        st_d.ctrl[3:0] = reg_wdata[3:0];
        if (st_q.ctrl[`USBEV_B_REINIT] && !reg_wdata[`USBEV_B_REINIT]) begin
          st_d.flags[`USBEV_B_BUSRST] = 1'b1;                          // [R22]
        end
      end
      // Endpoint good flags: set by good transfer, cleared by endpoint write.
      st_d.epg = st_q.epg & ~ep_good_clr;
      if (good && !ovr) begin
        st_d.epg[pkt_ep] = 1'b1;
      end
      st_d.stw = good && !ovr;                                         // [R11]
      if (brst) begin
        st_d.epg = '0;                                                 // [R16]
      end
      st_d.flags[`USBEV_B_GOOD] = |st_d.epg;                           // [R9]
      if (ovr)       st_d.flags[`USBEV_B_SETUP_OVERWRITE_FLAG]  = 1'b1;                // [R11]
      if (fault)     st_d.flags[`USBEV_B_FAULT] = 1'b1;                // [R12]
      if (sof_token) st_d.flags[`USBEV_B_FRAME] = 1'b1;                // [R17]
      if (st_q.sy_rst[1]) begin
        st_d.flags[`USBEV_B_BUSRST] = 1'b1;                            // [R16]
        st_d.ctrl[`USBEV_B_RSEEN]   = 1'b1;                            // [R20]
      end else if (st_q.sy_idle[1]) begin
        st_d.ctrl[`USBEV_B_RSEEN] = 1'b0;
      end
      if (st_q.sy_res[1]) begin
        st_d.ctrl[`USBEV_B_WSEEN] = 1'b1;                              // [R19]
      end else if (st_q.sy_idle[1]) begin
        st_d.ctrl[`USBEV_B_WSEEN] = 1'b0;
      end
      // Idle sleep detection.
      case (st_q.sleep)
        USBEV_AWAKE: begin
          if (brst || !st_q.sy_idle[1]) begin
            st_d.idle_cnt = '0;                                        // [R14]
          end else if (st_q.idle_cnt < CW'(IDLE_CYCLES)) begin
            st_d.idle_cnt = st_q.idle_cnt + 1'b1;
          end else if (st_q.idle_cnt == CW'(IDLE_CYCLES)) begin
            st_d.flags[`USBEV_B_SLEEP] = 1'b1;                         // [R13]
            st_d.idle_cnt = st_q.idle_cnt + 1'b1;
          end
          if (st_d.ctrl[`USBEV_B_SLFORCE]) begin
            st_d.sleep = USBEV_ASLEEP;                                 // [R14]
          end
        end
        USBEV_ASLEEP: begin
          st_d.idle_cnt = '0;
          if (activity) begin
            st_d.flags[`USBEV_B_WAKE]    = 1'b1;                       // [R15]
            st_d.ctrl[`USBEV_B_SLFORCE] = 1'b0;                        // [R21]
            st_d.sleep = USBEV_RESUME;
          end else if (!st_d.ctrl[`USBEV_B_SLFORCE]) begin
            st_d.sleep = USBEV_RESUME;
          end
        end
        USBEV_RESUME: begin
          st_d.idle_cnt = '0;
          if (st_q.sy_idle[1] && !st_q.sy_res[1] && !st_q.ctrl[`USBEV_B_RESUME]) begin
            st_d.sleep = USBEV_AWAKE;                                  // [R14]
          end
        end
        default: begin
          st_d.sleep = USBEV_AWAKE;
        end
      endcase
      if (brst && st_q.sleep != USBEV_ASLEEP) begin
        st_d.sleep    = USBEV_AWAKE;
        st_d.idle_cnt = '0;                                            // [R14]
      end
    end else if (st_q.sleep == USBEV_ASLEEP && activity) begin
      st_d.flags[`USBEV_B_WAKE]    = 1'b1;                             // [R2] [R15]
      st_d.ctrl[`USBEV_B_SLFORCE] = 1'b0;                              // [R21]
      st_d.sleep = USBEV_RESUME;
    end
    // Interrupt requests and wake.
    st_d.irq_w = !cpu_irq_mask && st_q.flags[`USBEV_B_WAKE]
                 && st_q.enables[`USBEV_B_WAKE];                       // [R3] [R4]
    st_d.irq_m = !cpu_irq_mask && |(st_q.flags & st_q.enables & 8'hBB); // [R3] [R4]
    st_d.wake  = |(st_q.flags & st_q.enables & `USBEV_FLAG_MASK);      // [R1]
    st_d.urst  = brst;                                                 // [R16] [R22]
  end

  // State register.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q         <= '0;
      st_q.sy_idle <= 3'b111;       // Idle level, so reset is not seen as bus activity.
      st_q.sleep   <= USBEV_AWAKE;
      st_q.ctrl  <= `USBEV_CTRL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ========================================================================
  // Block tracker hookup.
  assign blk.rx_done  = pkt_done && good && (pkt_ep == 2'b10);
  assign blk.rx_block = pkt_block;
  assign blk.fill_set = fill_set;
  assign blk.fill_clr = fill_clr;
  assign blk.wipe     = wr_block && reg_wdata[`USBEV_B_WIPE];          // [R7]
  assign blk.frozen   = frozen;

  usbev_blk_track u_blk (
    .clock   (clock),
    .rst_b   (rst_b),
    .bus_rst (brst),
    .route   (usbev_route_t'(route)),
    .blk     (blk.tracker)
  );

  // ========================================================================
  // Outputs.
  assign reg_rdata     = st_q.rdata;
  assign irq_wake      = st_q.irq_w;
  assign irq_main      = st_q.irq_m;
  assign cpu_wake      = st_q.wake;
  assign usb_reset_out = st_q.urst;
  assign status_write  = st_q.stw;
  assign resume_drive  = st_q.ctrl[`USBEV_B_RESUME];
  assign power_down    = st_q.ctrl[`USBEV_B_PWRDN];
  assign ep_good       = st_q.epg;
  assign pkt_count     = blk.pkt_cnt;

endmodule

//--- bench/usbev_core_chk.sv
`timescale 1ns/1ps
// ====
// Port checks of the event core.
module usbev_core_chk (
  input wire logic       clock,         // Clock.
  input wire logic       rst_b,         // Reset.
  input wire logic [7:0] reg_addr,      // Address.
  input wire logic       reg_rd,        // Read strobe.
  input wire logic [7:0] reg_rdata,     // Read data.
  input wire logic       cpu_halt,      // Halt.
  input wire logic       cpu_irq_mask,  // Global mask.
  input wire logic       bus_reset_seq, // Line reset.
  input wire logic       pkt_done,      // Packet end.
  input wire logic       pkt_nak_stall, // NAK or STALL.
  input wire logic       pkt_crc_err,   // CRC error.
  input wire logic [1:0] pkt_ep,        // Endpoint.
  input wire logic [2:0] ep_good,       // Good flags.
  input wire logic [3:0] pkt_count,     // Packet counter.
  input wire logic       irq_wake,      // Wake vector.
  input wire logic       irq_main,      // Shared vector.
  input wire logic       usb_reset_out  // Interface reset.
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // ====
  // A read aimed at one offset.
  sequence rd_at(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  // A line reset held past the synchroniser.
  sequence reset_held;
    (bus_reset_seq && !cpu_halt) [*6];
  endsequence
  // A failed packet on endpoint 1.
  sequence bad_ep1;
    pkt_done && pkt_ep == 2'b01 && !ep_good[1] && (pkt_crc_err || pkt_nak_stall);
  endsequence
  // ====
  // Assertions.
  read_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("rdata not idle");
  unmapped_read_a: assert property (reg_rd && reg_addr > 8'h03 |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  block_rsvd_a: assert property (rd_at(8'h00) |=> (reg_rdata & 8'hF1) == 8'h00)
    else $error("block reserved bits");
  good_or_a: assert property (rd_at(8'h01) ##0 $stable(ep_good) && ep_good == $past(ep_good, 2)
    |=> reg_rdata[7] == |$past(ep_good)) else $error("good flag not OR");
  irq_masked_a: assert property (cpu_irq_mask && $past(cpu_irq_mask) |-> !irq_main && !irq_wake)
    else $error("interrupt while masked");
  bad_pkt_a: assert property (bad_ep1 |=> !ep_good[1])
    else $error("bad packet counted");
  halt_freeze_a: assert property (cpu_halt |=> $stable(ep_good) && $stable(pkt_count))
    else $error("state changed in halt");
  reset_follow_a: assert property (reset_held |-> usb_reset_out)
    else $error("reset not passed");
endmodule

bind usbev_core usbev_core_chk u_chk (
  .clock, .rst_b, .reg_addr, .reg_rd, .reg_rdata, .cpu_halt, .cpu_irq_mask, .bus_reset_seq, .pkt_done,
  .pkt_nak_stall, .pkt_crc_err, .pkt_ep, .ep_good, .pkt_count, .irq_wake, .irq_main, .usb_reset_out
);

//--- bench/usbev_host.sv
`timescale 1ns/1ps
// ====
// Host side: line states, tokens and finished packets.
module usbev_host (
  input  wire logic       clock,   // Clock.
  output logic            idle,    // Line idle.
  output logic            rst_seq, // Reset sequence.
  output logic            res_seq, // Resume sequence.
  output logic            done,    // Packet end.
  output logic      [7:0] err,     // Bit 0 nak up to bit 7 timeout.
  output logic      [1:0] ep,      // Endpoint.
  output logic            setup,   // SETUP token.
  output logic            blk,     // Block used.
  output logic            sof      // SOF token.
);
  // The line rests idle.
  initial begin
    {rst_seq, res_seq, done, err, ep, setup, blk, sof} = '0;
    idle = 1'b1;
  end
  // Drives a line state for n cycles.
  task automatic line(input logic r, input logic s, input int n);
    @(posedge clock);
    {idle, rst_seq, res_seq} <= {1'b0, r, s};
    repeat (n) @(posedge clock);
    {idle, rst_seq, res_seq} <= 3'b100;
  endtask
  // Ends one packet.
  task automatic pkt(input logic [1:0] e, input logic s, input logic b, input logic [7:0] x);
    @(posedge clock);
    {idle, done, ep, setup, blk, err} <= {2'b01, e, s, b, x};
    @(posedge clock);
    {idle, done, ep, setup, blk, err} <= {2'b10, ~e, ~s, ~b, ~x};
  endtask
  // Sends one SOF token.
  task automatic frame();
    @(posedge clock);
    {idle, sof} <= 2'b01;
    @(posedge clock);
    {idle, sof} <= 2'b10;
  endtask
endmodule

//--- bench/usb_event_and_buffer_status_tb_top.sv
`timescale 1ns/1ps
// ====
// Self-checking bench of the event and block-status core.
module usb_event_and_buffer_status_tb_top;
  logic       clock, rst_b, reg_wr, reg_rd, cpu_halt, cpu_irq_mask, irq_wake, irq_main, cpu_wake;
  logic       usb_reset_out, status_write, resume_drive, power_down, bus_idle, bus_reset_seq;
  logic       bus_resume_seq, pkt_done, pkt_setup, pkt_block, sof_token;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, err;
  logic [2:0] ep_good_clr, ep_good;
  logic [1:0] route, fill_set, fill_clr, pkt_ep;
  logic [3:0] pkt_count;
  int         bad_count, n_checks;

  usbev_core #(.IDLE_CYCLES(20)) DUT (
    .clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_halt, .cpu_irq_mask,
    .bus_idle, .bus_reset_seq, .bus_resume_seq, .pkt_done, .pkt_nak_stall(err[0]), .pkt_pid_err(err[1]),
    .pkt_crc_err(err[2]), .pkt_toggle_bad(err[3]), .pkt_stuff_err(err[4]), .pkt_frame_err(err[5]),
    .pkt_overrun(err[6]), .pkt_timeout(err[7]), .pkt_ep, .pkt_setup, .pkt_block, .sof_token, .ep_good_clr,
    .route, .fill_set, .fill_clr, .irq_wake, .irq_main, .cpu_wake, .usb_reset_out, .status_write,
    .resume_drive, .power_down, .ep_good, .pkt_count);
  usbev_host host (.clock(clock), .idle(bus_idle), .rst_seq(bus_reset_seq), .res_seq(bus_resume_seq),
    .done(pkt_done), .err(err), .ep(pkt_ep), .setup(pkt_setup), .blk(pkt_block), .sof(sof_token));

  // A 40 MHz clock.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // ====
  // Bus cycles and comparisons.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Compares a result under a mask.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    n_checks++;
    if ((got & m) !== (exp & m)) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h mask %h", $time, got, exp, m);
    end
  endtask
  // Reads one register and compares it.
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge clock);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(reg_rdata, exp, m);
  endtask
  // Waits n edges, then a falling edge.
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  // One-cycle clear of endpoint good flags.
  task automatic clr_good(input logic [2:0] m);
    @(posedge clock);
    ep_good_clr <= m;
    @(posedge clock);
    ep_good_clr <= 3'b000;
  endtask
  // Prints the counts and the verdict.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    finish_test();
  end
  // ====
  // Main sequence.
  initial begin : main
    logic [7:0] v;
    logic [1:0] f;
    int         e;
    {rst_b, reg_addr, reg_wdata, reg_wr, reg_rd, cpu_halt, cpu_irq_mask} = '0;
    {ep_good_clr, route, fill_set, fill_clr} = '0;
    bad_count = 0;
    n_checks = 0;
    void'($urandom(70));
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    rchk(8'h00, 8'h00, 8'hFF);
    rchk(8'h01, 8'h00, 8'hFF);
    rchk(8'h03, 8'h06, 8'hFF);
    rchk(8'h04 + 8'($urandom_range(250)), 8'h00, 8'hFF);
    v = 8'($urandom);
    wr(8'h02, v);
    rchk(8'h02, v & 8'hBF, 8'hFF);
    wr(8'h02, 8'h00);
    // Bus reset, then idle detection.
    fork
      host.line(1'b1, 1'b0, 20);
      begin
        settle(10);
        rchk(8'h03, 8'h40, 8'h40);
      end
    join
    settle(4);
    rchk(8'h03, 8'h00, 8'h02);
    rchk(8'h01, 8'h02, 8'h02);
    settle(40);
    rchk(8'h01, 8'h08, 8'h08);
    wr(8'h01, 8'hF5);
    rchk(8'h01, 8'h00, 8'h02);
    wr(8'h01, 8'hFF);
    rchk(8'h01, 8'h00, 8'h02);
    // Frame start on the shared vector.
    wr(8'h02, 8'h01);
    host.frame();
    settle(3);
    chk({5'b0, cpu_wake, irq_wake, irq_main}, 8'h05, 8'h07);
    @(posedge clock);
    cpu_irq_mask <= 1'b1;
    settle(3);
    chk({7'b0, irq_main}, 8'h00, 8'h01);
    @(posedge clock);
    cpu_irq_mask <= 1'b0;
    wr(8'h01, 8'hFE);
    settle(3);
    chk({5'b0, cpu_wake, irq_wake, irq_main}, 8'h00, 8'h07);
    // Each endpoint: good packet, clear, then a failed packet.
    for (int i = 0; i < 3; i++) begin
      e = $urandom_range(7);
      host.pkt(2'(i), 1'b0, 1'b0, 8'h00);
      settle(3);
      chk({5'b0, ep_good}, 8'h01 << i, 8'h07);
      wr(8'h01, 8'h6B);
      rchk(8'h01, 8'h80, 8'h90);
      clr_good(3'(1 << i));
      rchk(8'h01, 8'h00, 8'h80);
      host.pkt(2'(i), 1'b0, 1'b0, 8'h01 << e);
      settle(3);
      chk({5'b0, ep_good}, 8'h00, 8'h07);
      rchk(8'h01, (e inside {2, 4, 5, 6, 7}) ? 8'h10 : 8'h00, 8'h10);
    end
    // A second good SETUP before the first is serviced.
    host.pkt(2'b00, 1'b1, 1'b0, 8'h00);
    host.pkt(2'b00, 1'b1, 1'b0, 8'h00);
    rchk(8'h01, 8'hA0, 8'hA0);
    clr_good(3'b001);
    // Block index, fill bits per routing, and the wipe.
    host.pkt(2'b10, 1'b0, 1'b1, 8'h00);
    rchk(8'h00, 8'h08, 8'h08);
    clr_good(3'b100);
    for (int r = 1; r < 3; r++) begin
      f = 2'($urandom_range(3, 1));
      @(posedge clock);
      {route, fill_set} <= {2'(r), f};
      @(posedge clock);
      fill_set <= 2'b00;
      rchk(8'h00, {5'b0, f, 1'b0}, 8'h06);
      @(posedge clock);
      fill_clr <= f & 2'b01;
      @(posedge clock);
      fill_clr <= 2'b00;
      rchk(8'h00, {5'b0, f & 2'b10, 1'b0}, 8'h06);
      wr(8'h00, 8'h01);
      rchk(8'h00, 8'h00, 8'hFF);
      chk({4'b0, pkt_count}, 8'h00, 8'hFF);
    end
    // Writes are ignored in halt.
    @(posedge clock);
    cpu_halt <= 1'b1;
    wr(8'h02, 8'hFF);
    cpu_halt <= 1'b0;
    rchk(8'h02, 8'h01, 8'hFF);
    // Forced sleep in halt; resume wakes.
    wr(8'h02, 8'h04);
    wr(8'h03, 8'h02);
    @(posedge clock);
    cpu_halt <= 1'b1;
    fork
      host.line(1'b0, 1'b1, 30);
      begin
        settle(12);
        chk({5'b0, cpu_wake, irq_wake, irq_main}, 8'h06, 8'h07);
        @(posedge clock);
        cpu_halt <= 1'b0;
        rchk(8'h03, 8'h80, 8'h80);
      end
    join
    rchk(8'h01, 8'h04, 8'h04);
    // Forced reinit and its release.
    host.pkt(2'b01, 1'b0, 1'b0, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h03, 8'h01);
    settle(3);
    chk({6'b0, usb_reset_out, ep_good[1]}, 8'h02, 8'h03);
    wr(8'h03, 8'h00);
    rchk(8'h01, 8'h02, 8'h02);
    finish_test();
  end
endmodule
